// *** src/tlic_defines.svh ***
// Purpose: offsets, field positions, reset values and counts of the interrupt controller
// Assumes: byte addresses on a 32-bit APB, one register per aligned word
// Notes: definitions only
`ifndef TLIC_DEFINES_SVH
`define TLIC_DEFINES_SVH

`define TLIC_NUM_SRC 13
`define TLIC_ADDR_W 12
`define TLIC_OFS_TIMER_IRQ_CONTROL 12'h088
`define TLIC_OFS_BASE_IRQ_ENABLE 12'h0A8
`define TLIC_OFS_BASE_LEVEL_SELECT 12'h0B8
`define TLIC_OFS_SOURCE_FLAGS 12'h0C0
`define TLIC_OFS_EVENT_STATUS 12'h0C4
`define TLIC_OFS_EVENT_MASK 12'h0C8
`define TLIC_OFS_EXT_IRQ_ENABLE 12'h0E8
`define TLIC_OFS_EXT_LEVEL_SELECT 12'h0F8
`define TLIC_RST_REG8 8'h00
`define TLIC_RST_EVT 3'h0
`define TLIC_TIMER_IRQ_CONTROL_CTL_MASK 8'h55
`define TLIC_BIT_MASTER_GATE 7
`define TLIC_BIT_T1_FLAG 7
`define TLIC_BIT_T1_RUN 6
`define TLIC_BIT_T0_FLAG 5
`define TLIC_BIT_T0_RUN 4
`define TLIC_BIT_ADC_FLAG 3
`define TLIC_BIT_ADC_TRIG 2
`define TLIC_BIT_TMA_FLAG 1
`define TLIC_BIT_TMA_TRIG 0
`define TLIC_BASE_SRC_W 7
`define TLIC_EXT_SRC_W 6
`define TLIC_PERIPH_W 9
`define TLIC_SRC_TIMER_A 4'h0
`define TLIC_SRC_TIMER0 4'h1
`define TLIC_SRC_ADC 4'h2
`define TLIC_SRC_TIMER1 4'h3
`define TLIC_VEC_BASE 8'h03
`define TLIC_VEC_SHIFT 3
`define TLIC_EVT_W 3
`define TLIC_EVT_HIGH_TAKE 0
`define TLIC_EVT_LOW_TAKE 1
`define TLIC_EVT_RETURN 2

`endif

// *** src/tlic_pkg.sv ***
// Purpose: types shared by the interrupt controller modules
// Assumes: tlic_defines.svh holds all numbers
// Notes: each module keeps its whole state in one packed struct
package tlic_pkg;
    `include "tlic_defines.svh"

    typedef logic [`TLIC_NUM_SRC-1:0] tlic_src_vec_t;
    typedef logic [3:0] tlic_src_num_t;

    // Nesting depth of running service routines
    typedef enum logic [1:0] {
        TLIC_SVC_IDLE,
        TLIC_SVC_LOW,
        TLIC_SVC_HIGH,
        TLIC_SVC_NESTED
    } tlic_svc_t;

    typedef struct packed {
        tlic_src_vec_t flag;
    } tlic_flag_state_t;

    typedef struct packed {
        logic [7:0] timer_irq_control_ctl;
        logic [7:0] base_en;
        logic [7:0] base_lvl;
        logic [7:0] ext_en;
        logic [7:0] ext_lvl;
        logic [`TLIC_EVT_W-1:0] evt_status;
        logic [`TLIC_EVT_W-1:0] evt_mask;
        logic irq_line;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic tma_prev;
        logic adc_prev;
        tlic_svc_t svc;
        logic req;
        logic high;
        tlic_src_num_t num;
        logic [7:0] vector;
        logic take;
    } tlic_top_state_t;
endpackage : tlic_pkg

// *** src/tlic_flags.sv ***
// Purpose: latched pending flag of each interrupt source
// Assumes: set, software clear and hardware clear arrive as one-cycle vectors
// Notes: a set in the same cycle as a clear keeps the flag
`timescale 1ns/1ps
module tlic_flags
    import tlic_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire tlic_src_vec_t set_evt,
    input wire tlic_src_vec_t sw_clr,
    input wire tlic_src_vec_t hw_clr,
    output tlic_src_vec_t flag
);
    tlic_flag_state_t st_r;
    tlic_flag_state_t st_nxt;

    always_comb
    begin
        st_nxt = st_r;
        // Flags latch whatever the enables say
        st_nxt.flag = (st_r.flag & ~(sw_clr | hw_clr)) | set_evt;
    end

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign flag = st_r.flag;
endmodule : tlic_flags

// *** src/tlic_arbiter.sv ***
// Purpose: picks the winning source over two priority groups
// Assumes: service depth comes from the controller's nesting state
// Notes: purely combinational
`timescale 1ns/1ps
module tlic_arbiter
    import tlic_pkg::*;
(
    input wire tlic_src_vec_t flag,
    input wire tlic_src_vec_t unmask,
    input wire tlic_src_vec_t high_level,
    input wire logic master_gate,
    input wire tlic_svc_t svc,
    output logic req,
    output logic high,
    output tlic_src_num_t num
);
    tlic_src_vec_t eligible;

    genvar g;
    generate
        for (g = 0; g < `TLIC_NUM_SRC; g++)
        begin : g_elig
            assign eligible[g] = flag[g] & unmask[g] & master_gate;
        end
    endgenerate

    logic hi_found;
    logic lo_found;
    tlic_src_num_t hi_num;
    tlic_src_num_t lo_num;

    always_comb
    begin
        hi_found = 1'b0;
        lo_found = 1'b0;
        hi_num = '0;
        lo_num = '0;
        // Walk downward so the lowest vector number is left standing
        for (int i = `TLIC_NUM_SRC - 1; i >= 0; i--)
        begin
            if (eligible[i] && high_level[i])
            begin
                hi_found = 1'b1;
                hi_num = tlic_src_num_t'(i);
            end
            else if (eligible[i])
            begin
                lo_found = 1'b1;
                lo_num = tlic_src_num_t'(i);
            end
        end
    end

    always_comb
    begin
        req = 1'b0;
        high = 1'b0;
        num = lo_num;
        case (svc)
            TLIC_SVC_IDLE:
            begin
                req = hi_found | lo_found;
                high = hi_found;
                num = hi_found ? hi_num : lo_num;
            end
            TLIC_SVC_LOW:
            begin
                req = hi_found;
                high = hi_found;
                num = hi_num;
            end
            default:
            begin
                req = 1'b0;
                high = 1'b0;
                num = lo_num;
            end
        endcase
    end
endmodule : tlic_arbiter

// *** src/tlic_top.sv ***
// Purpose: two-group vectored interrupt controller with APB register access
// Assumes: all inputs synchronous to sys_clk; CPU signals instruction boundaries and returns
// Notes: APB answers with no wait state; unmapped addresses answer with pslverr
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps

module tlic_top
    import tlic_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`TLIC_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic timer_a_req_n,
    input wire logic adc_req_n,
    input wire logic timer0_ovf,
    input wire logic timer1_ovf,
    input wire logic [`TLIC_PERIPH_W-1:0] periph_evt,
    input wire logic inst_boundary,
    input wire logic cpu_return,
    output logic irq_req,
    output logic irq_high,
    output logic [7:0] irq_vector,
    output logic irq_take,
    output logic timer0_run,
    output logic timer1_run,
    output logic irq_line
);
    tlic_top_state_t st_r;
    tlic_top_state_t st_nxt;

    tlic_src_vec_t flag;
    tlic_src_vec_t set_evt;
    tlic_src_vec_t sw_clr;
    tlic_src_vec_t hw_clr;
    tlic_src_vec_t unmask;
    tlic_src_vec_t high_level;
    logic arb_req;
    logic arb_high;
    tlic_src_num_t arb_num;

    // APB phase decode
    logic setup;
    logic done;
    logic wr_lo;
    logic wr_hi;
    logic rd_done;
    logic hit_timer_irq_control;
    logic hit_ben;
    logic hit_blvl;
    logic hit_flags;
    logic hit_status;
    logic hit_mask;
    logic hit_een;
    logic hit_elvl;
    logic hit_any;

    // Source input conditioning, take accept, event status and read data
    logic tma_set;
    logic adc_set;
    logic accept;
    logic [`TLIC_EVT_W-1:0] evt;
    logic [`TLIC_EVT_W-1:0] status_hold;
    logic [7:0] timer_irq_control_rd;
    logic [31:0] rd_word;

    assign setup = psel & ~penable;
    assign done = psel & penable & st_r.pready;
    assign wr_lo = done & pwrite & pstrb[0];
    assign wr_hi = done & pwrite & pstrb[1];
    assign rd_done = done & ~pwrite;

    assign hit_timer_irq_control = (paddr == `TLIC_OFS_TIMER_IRQ_CONTROL);
    assign hit_ben = (paddr == `TLIC_OFS_BASE_IRQ_ENABLE);
    assign hit_blvl = (paddr == `TLIC_OFS_BASE_LEVEL_SELECT);
    assign hit_flags = (paddr == `TLIC_OFS_SOURCE_FLAGS);
    assign hit_status = (paddr == `TLIC_OFS_EVENT_STATUS);
    assign hit_mask = (paddr == `TLIC_OFS_EVENT_MASK);
    assign hit_een = (paddr == `TLIC_OFS_EXT_IRQ_ENABLE);
    assign hit_elvl = (paddr == `TLIC_OFS_EXT_LEVEL_SELECT);
    assign hit_any = hit_timer_irq_control | hit_ben | hit_blvl | hit_flags | hit_status
                   | hit_mask | hit_een | hit_elvl;

    // Level mode sets while the line is low; edge mode sets on a falling edge
    assign tma_set = st_r.timer_irq_control_ctl[`TLIC_BIT_TMA_TRIG] ? (st_r.tma_prev & ~timer_a_req_n)
                                                       : ~timer_a_req_n;
    assign adc_set = st_r.timer_irq_control_ctl[`TLIC_BIT_ADC_TRIG] ? (st_r.adc_prev & ~adc_req_n)
                                                       : ~adc_req_n;

    assign set_evt = {periph_evt, timer1_ovf, adc_set, timer0_ovf, tma_set};

    // Source order: base sources 0..6, extended sources 7..12
    assign unmask = {st_r.ext_en[`TLIC_EXT_SRC_W-1:0], st_r.base_en[`TLIC_BASE_SRC_W-1:0]};
    assign high_level = {st_r.ext_lvl[`TLIC_EXT_SRC_W-1:0],
                         st_r.base_lvl[`TLIC_BASE_SRC_W-1:0]};

    // A written zero clears a flag; a written one leaves it alone
    always_comb
    begin
        sw_clr = '0;
        if (wr_lo && hit_timer_irq_control)
        begin
            sw_clr[`TLIC_SRC_TIMER_A] = ~pwdata[`TLIC_BIT_TMA_FLAG];
            sw_clr[`TLIC_SRC_TIMER0] = ~pwdata[`TLIC_BIT_T0_FLAG];
            sw_clr[`TLIC_SRC_ADC] = ~pwdata[`TLIC_BIT_ADC_FLAG];
            sw_clr[`TLIC_SRC_TIMER1] = ~pwdata[`TLIC_BIT_T1_FLAG];
        end
        if (wr_lo && hit_flags)
        begin
            sw_clr[`TLIC_NUM_SRC-2:`TLIC_NUM_SRC-`TLIC_PERIPH_W] = ~pwdata[7:0];
        end
        if (wr_hi && hit_flags)
        begin
            sw_clr[`TLIC_NUM_SRC-1] = ~pwdata[8];
        end
    end

    // Stale request is blocked in the cycle right after a take
    assign accept = inst_boundary & st_r.req & ~st_r.take;

    always_comb
    begin
        hw_clr = '0;
        if (accept && (st_r.num == `TLIC_SRC_TIMER0 || st_r.num == `TLIC_SRC_TIMER1))
        begin
            hw_clr[st_r.num] = 1'b1;
        end
    end

    tlic_flags u_flags (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .set_evt(set_evt),
        .sw_clr(sw_clr),
        .hw_clr(hw_clr),
        .flag(flag)
    );

    tlic_arbiter u_arbiter (
        .flag(flag),
        .unmask(unmask),
        .high_level(high_level),
        .master_gate(st_r.base_en[`TLIC_BIT_MASTER_GATE]),
        .svc(st_r.svc),
        .req(arb_req),
        .high(arb_high),
        .num(arb_num)
    );

    assign timer_irq_control_rd = {flag[`TLIC_SRC_TIMER1], st_r.timer_irq_control_ctl[`TLIC_BIT_T1_RUN],
                      flag[`TLIC_SRC_TIMER0], st_r.timer_irq_control_ctl[`TLIC_BIT_T0_RUN],
                      flag[`TLIC_SRC_ADC], st_r.timer_irq_control_ctl[`TLIC_BIT_ADC_TRIG],
                      flag[`TLIC_SRC_TIMER_A], st_r.timer_irq_control_ctl[`TLIC_BIT_TMA_TRIG]};

    // Read mux, evaluated in the setup cycle
    always_comb
    begin
        rd_word = '0;
        if (hit_timer_irq_control)
        begin
            rd_word = {24'h000000, timer_irq_control_rd};
        end
        else if (hit_ben)
        begin
            rd_word = {24'h000000, st_r.base_en};
        end
        else if (hit_blvl)
        begin
            rd_word = {24'h000000, st_r.base_lvl};
        end
        else if (hit_flags)
        begin
            rd_word = {23'h000000, flag[`TLIC_NUM_SRC-1:`TLIC_NUM_SRC-`TLIC_PERIPH_W]};
        end
        else if (hit_status)
        begin
            rd_word = {29'h00000000, st_r.evt_status};
        end
        else if (hit_mask)
        begin
            rd_word = {29'h00000000, st_r.evt_mask};
        end
        else if (hit_een)
        begin
            rd_word = {24'h000000, st_r.ext_en};
        end
        else if (hit_elvl)
        begin
            rd_word = {24'h000000, st_r.ext_lvl};
        end
        else
        begin
            rd_word = '0;
        end
    end

    assign evt[`TLIC_EVT_HIGH_TAKE] = accept & st_r.high;
    assign evt[`TLIC_EVT_LOW_TAKE] = accept & ~st_r.high;
    assign evt[`TLIC_EVT_RETURN] = cpu_return & (st_r.svc != TLIC_SVC_IDLE);

    // A status read clears only the bits it returned, so an event after the setup edge is kept
    assign status_hold = (rd_done && hit_status) ? (st_r.evt_status & ~st_r.prdata[`TLIC_EVT_W-1:0]) : st_r.evt_status;

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.tma_prev = timer_a_req_n;
        st_nxt.adc_prev = adc_req_n;

        // APB slave: pready in the first access cycle
        st_nxt.pready = setup;
        if (setup)
        begin
            st_nxt.prdata = pwrite ? 32'h00000000 : rd_word;
            st_nxt.pslverr = ~hit_any;
        end
        else if (done)
        begin
            st_nxt.prdata = '0;
            st_nxt.pslverr = 1'b0;
        end

        if (wr_lo)
        begin
            if (hit_timer_irq_control)
            begin
                st_nxt.timer_irq_control_ctl = pwdata[7:0] & `TLIC_TIMER_IRQ_CONTROL_CTL_MASK;
            end
            else if (hit_ben)
            begin
                st_nxt.base_en = pwdata[7:0];
            end
            else if (hit_blvl)
            begin
                st_nxt.base_lvl = pwdata[7:0];
            end
            else if (hit_mask)
            begin
                st_nxt.evt_mask = pwdata[`TLIC_EVT_W-1:0];
            end
            else if (hit_een)
            begin
                st_nxt.ext_en = pwdata[7:0];
            end
            else if (hit_elvl)
            begin
                st_nxt.ext_lvl = pwdata[7:0];
            end
        end

        st_nxt.evt_status = status_hold | evt;
        st_nxt.irq_line = |(st_nxt.evt_status & st_nxt.evt_mask);

        // Registered request presented to the CPU
        st_nxt.req = arb_req;
        st_nxt.high = arb_high;
        st_nxt.num = arb_num;
        st_nxt.vector = 8'(`TLIC_VEC_BASE + (8'(arb_num) << `TLIC_VEC_SHIFT));
        st_nxt.take = accept;

        // Nesting of running routines; a return pops the innermost
        case (st_r.svc)
            TLIC_SVC_IDLE:
            begin
                if (accept)
                begin
                    st_nxt.svc = st_r.high ? TLIC_SVC_HIGH : TLIC_SVC_LOW;
                end
            end
            TLIC_SVC_LOW:
            begin
                if (cpu_return)
                begin
                    st_nxt.svc = TLIC_SVC_IDLE;
                end
                else if (accept && st_r.high)
                begin
                    st_nxt.svc = TLIC_SVC_NESTED;
                end
            end
            TLIC_SVC_HIGH:
            begin
                if (cpu_return)
                begin
                    st_nxt.svc = TLIC_SVC_IDLE;
                end
            end
            TLIC_SVC_NESTED:
            begin
                if (cpu_return)
                begin
                    st_nxt.svc = TLIC_SVC_LOW;
                end
            end
            default:
            begin
                st_nxt.svc = TLIC_SVC_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st_r <= '0;
            st_r.timer_irq_control_ctl <= `TLIC_RST_REG8;
            st_r.base_en <= `TLIC_RST_REG8;
            st_r.base_lvl <= `TLIC_RST_REG8;
            st_r.ext_en <= `TLIC_RST_REG8;
            st_r.ext_lvl <= `TLIC_RST_REG8;
            st_r.tma_prev <= 1'b1;
            st_r.adc_prev <= 1'b1;
            st_r.svc <= TLIC_SVC_IDLE;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign prdata = st_r.prdata;
    assign pready = st_r.pready;
    assign pslverr = st_r.pslverr;
    assign irq_req = st_r.req;
    assign irq_high = st_r.high;
    assign irq_vector = st_r.vector;
    assign irq_take = st_r.take;
    assign timer0_run = st_r.timer_irq_control_ctl[`TLIC_BIT_T0_RUN];
    assign timer1_run = st_r.timer_irq_control_ctl[`TLIC_BIT_T1_RUN];
    assign irq_line = st_r.irq_line;
endmodule : tlic_top

// *** testbench/tlic_top_chk.sv ***
// Purpose: port-level checks of the interrupt controller
// Assumes: one clock domain, reset active high
// Notes: bound into tlic_top
`timescale 1ns/1ps
module tlic_top_chk
    import tlic_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic inst_boundary,
    input wire logic irq_req,
    input wire logic irq_high,
    input wire logic [7:0] irq_vector,
    input wire logic irq_take,
    input wire logic timer0_run,
    input wire logic timer1_run
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    logic ctl_wr;
    assign ctl_wr = psel && penable && pready && pwrite && paddr == 12'h088 && pstrb[0];
    sequence s_accept;
        inst_boundary && irq_req && !irq_take;
    endsequence
    property p_take_once;
        irq_take |=> !irq_take;
    endproperty
    a_take_once: assert property (p_take_once) else $error("take too long");
    property p_take_cause;
        s_accept |=> irq_take;
    endproperty
    a_take_cause: assert property (p_take_cause) else $error("request not taken");
    property p_take_only;
        !(inst_boundary && irq_req && !irq_take) |=> !irq_take;
    endproperty
    a_take_only: assert property (p_take_only) else $error("take without request");
    property p_vector;
        irq_req |-> irq_vector[2:0] == 3'h3 && irq_vector <= 8'h63;
    endproperty
    a_vector: assert property (p_vector) else $error("vector out of table");
    property p_run;
        ctl_wr |=> timer0_run == $past(pwdata[4]) && timer1_run == $past(pwdata[6]);
    endproperty
    a_run: assert property (p_run) else $error("run bits wrong");
    property p_ready;
        psel && !penable |-> ##1 pready;
    endproperty
    a_ready: assert property (p_ready) else $error("no ready in access");
    property p_ready_one;
        pready |=> !pready;
    endproperty
    a_ready_one: assert property (p_ready_one) else $error("ready held");
    property p_err;
        pslverr |-> pready;
    endproperty
    a_err: assert property (p_err) else $error("error without ready");
    c_high: cover property (irq_take && irq_high);
    c_low: cover property (irq_take && !irq_high);
    c_err: cover property (pslverr);
endmodule : tlic_top_chk

bind tlic_top tlic_top_chk i_tlic_top_chk (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .pslverr(pslverr), .inst_boundary(inst_boundary), .irq_req(irq_req), .irq_high(irq_high),
    .irq_vector(irq_vector), .irq_take(irq_take), .timer0_run(timer0_run), .timer1_run(timer1_run));

// *** testbench/tlic_cpu_model.sv ***
// Purpose: CPU side that takes vectored requests and returns from service
// Assumes: returns only when the bench asks
// Notes: slow mode spaces instruction boundaries four cycles apart
`timescale 1ns/1ps
module tlic_cpu_model
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic irq_take,
    input wire logic ret_go,
    input wire logic slow,
    output logic inst_boundary,
    output logic cpu_return,
    output logic [7:0] take_cnt
);
    logic [1:0] jump_r;
    logic [1:0] cyc_r;
    logic [1:0] depth_r;

    // No boundary while the jump to the vector is under way
    assign inst_boundary = jump_r == 2'h0 && (!slow || cyc_r == 2'h0);

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            jump_r <= 2'h0;
            cyc_r <= 2'h0;
            depth_r <= 2'h0;
            take_cnt <= 8'h00;
            cpu_return <= 1'b0;
        end
        else
        begin
            cyc_r <= cyc_r + 2'h1;
            jump_r <= irq_take ? 2'h3 : (jump_r == 2'h0 ? 2'h0 : jump_r - 2'h1);
            cpu_return <= ret_go && depth_r != 2'h0;
            if (irq_take)
            begin
                depth_r <= depth_r + 2'h1;
                take_cnt <= take_cnt + 8'h01;
            end
            else if (cpu_return)
                depth_r <= depth_r - 2'h1;
        end
    end
endmodule : tlic_cpu_model

// *** testbench/tlic_tb_top.sv ***
// Purpose: directed tests of the two-group interrupt controller
// Assumes: bench is APB master and source driver, CPU model answers takes
// Notes: src_on bit n raises source n while held
`timescale 1ns/1ps
module two_level_irq_controller_tb_top import tlic_pkg::*;;
    logic sys_clk, sys_rst, psel, penable, pwrite, pready, pslverr, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [3:0] pstrb;
    logic [12:0] src_on;
    logic inst_boundary, cpu_return, irq_req, irq_high, irq_take, timer0_run, timer1_run, irq_line, ret_go, slow;
    logic [7:0] irq_vector, take_cnt;
    logic [11:0] regs [6] = '{12'h088, 12'h0A8, 12'h0B8, 12'h0E8, 12'h0F8, 12'h0C0};
    int err_total, tests_run;

    tlic_top i_tlic_top (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timer_a_req_n(~src_on[0]), .adc_req_n(~src_on[2]), .timer0_ovf(src_on[1]),
        .timer1_ovf(src_on[3]), .periph_evt(src_on[12:4]), .inst_boundary(inst_boundary),
        .cpu_return(cpu_return), .irq_req(irq_req), .irq_high(irq_high), .irq_vector(irq_vector),
        .irq_take(irq_take), .timer0_run(timer0_run), .timer1_run(timer1_run), .irq_line(irq_line));
    tlic_cpu_model i_tlic_cpu_model (.sys_clk(sys_clk), .sys_rst(sys_rst), .irq_take(irq_take),
        .ret_go(ret_go), .slow(slow), .inst_boundary(inst_boundary), .cpu_return(cpu_return),
        .take_cnt(take_cnt));

    task automatic finish_test;
        $display("tests_run %0d err_total %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : finish_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1)
        begin
            @(posedge sys_clk);
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(q, x);
    endtask : rd

    task automatic ev(input logic [12:0] m);
        @(posedge sys_clk);
        src_on <= m;
        @(posedge sys_clk);
        src_on <= 13'h0;
    endtask : ev

    task automatic ret;
        @(posedge sys_clk);
        ret_go <= 1'b1;
        @(posedge sys_clk);
        ret_go <= 1'b0;
    endtask : ret

    task automatic wt(input logic [7:0] v);
        int n;
        n = 0;
        @(posedge sys_clk);
        while (irq_take !== 1'b1 && n < 60)
        begin
            n++;
            @(posedge sys_clk);
        end
        chk({23'h0, irq_take, irq_vector}, {24'h1, v});
    endtask : wt

    task automatic idle(input int n);
        logic [7:0] c;
        c = take_cnt;
        repeat (n) @(posedge sys_clk);
        chk({24'h0, take_cnt}, {24'h0, c});
    endtask : idle

    initial
    begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    initial
    begin
        repeat (30000) @(posedge sys_clk);
        err_total++;
        finish_test;
    end

    initial
    begin
        {psel, penable, pwrite, paddr, pwdata, src_on, ret_go, slow} = '0;
        pstrb = 4'hF;
        err_total = 0;
        tests_run = 0;
        sys_rst = 1'b1;
        repeat (16) @(posedge sys_clk);
        sys_rst <= 1'b0;
        foreach (regs[i]) rd(regs[i], 32'h0);
        for (int i = 1; i < 5; i++)
        begin
            wr(regs[i], 32'h5A);
            rd(regs[i], 32'h5A);
            wr(regs[i], 32'h0);
        end
        wr(12'h100, 32'hFF);
        chk({31'h0, e}, 32'h1);
        rd(12'h100, 32'h0);
        chk({31'h0, e}, 32'h1);
        wr(12'h088, 32'h50);
        @(posedge sys_clk);
        chk({30'h0, timer1_run, timer0_run}, 32'h3);
        wr(12'h088, 32'h10);
        @(posedge sys_clk);
        chk({30'h0, timer1_run, timer0_run}, 32'h1);
        rd(12'h088, 32'h10);
        for (int i = 0; i < 2; i++)
        begin
            wr(12'h088, 32'h0);
            @(posedge sys_clk);
            src_on <= 13'h1 << (2 * i);
            wr(12'h088, 32'h0);
            rd(12'h088, 32'h2 << (2 * i));
            @(posedge sys_clk);
            src_on <= 13'h0;
            wr(12'h088, 32'h0);
            rd(12'h088, 32'h0);
            wr(12'h088, 32'h1 << (2 * i));
            @(posedge sys_clk);
            src_on <= 13'h1 << (2 * i);
            rd(12'h088, 32'h3 << (2 * i));
            wr(12'h088, 32'h1 << (2 * i));
            rd(12'h088, 32'h1 << (2 * i));
            @(posedge sys_clk);
            src_on <= 13'h0;
        end
        wr(12'h088, 32'h0);
        wr(12'h0E8, 32'h3F);
        wr(12'h0A8, 32'h7F);
        ev(13'h2);
        repeat (3) @(posedge sys_clk);
        chk({31'h0, irq_req}, 32'h0);
        rd(12'h088, 32'h20);
        wr(12'h0A8, 32'hFF);
        wt(8'h0B);
        rd(12'h088, 32'h0);
        ret;
        slow <= 1'b1;
        for (int s = 0; s < 13; s++)
        begin
            ev(13'h1 << s);
            wt(8'h03 + 8'(8 * s));
            wr(12'h088, 32'h0);
            wr(12'h0C0, 32'h0);
            ret;
        end
        slow <= 1'b0;
        wr(12'h0F8, 32'h04);
        ev(13'h0221);
        wt(8'h4B);
        chk({31'h0, irq_high}, 32'h1);
        wr(12'h0C0, 32'h1DF);
        ret;
        wt(8'h03);
        chk({31'h0, irq_high}, 32'h0);
        wr(12'h088, 32'h0);
        ret;
        wt(8'h2B);
        wr(12'h0C0, 32'h0);
        ev(13'h0200);
        wt(8'h4B);
        wr(12'h0C0, 32'h0);
        ev(13'h0010);
        idle(20);
        ret;
        idle(10);
        ret;
        wt(8'h23);
        rd(12'h0C4, 32'h7);
        wr(12'h0C8, 32'h2);
        wr(12'h0C0, 32'h0);
        ret;
        repeat (3) @(posedge sys_clk);
        chk({31'h0, irq_line}, 32'h0);
        ev(13'h0040);
        wt(8'h33);
        repeat (3) @(posedge sys_clk);
        chk({31'h0, irq_line}, 32'h1);
        rd(12'h0C4, 32'h6);
        repeat (2) @(posedge sys_clk);
        chk({31'h0, irq_line}, 32'h0);
        finish_test;
    end
endmodule : two_level_irq_controller_tb_top
